// file: include/tmr8_map.vh
// Register offsets, field positions, reset values and timing counts of the 8-bit timer.
`ifndef TMR8_MAP_VH
`define TMR8_MAP_VH
`define TMR8_ADDR_COUNT 8'h01
`define TMR8_ADDR_INTCTL 8'h0b
`define TMR8_ADDR_OPTION 8'h81
`define TMR8_ADDR_IRQ_STAT 8'h90
`define TMR8_ADDR_IRQ_EN 8'h91
`define TMR8_ADDR_IRQ_CLR 8'h92
`define TMR8_OPT_RESET 8'hff
`define TMR8_OPT_SRC 5
`define TMR8_OPT_EDGE 4
`define TMR8_OPT_ASSIGN 3
`define TMR8_INT_OVF_EN 5
`define TMR8_INT_OVF_FLAG 2
`define TMR8_PHASES 4
`define TMR8_WRITE_HOLD 2'h2
`endif

// file: hdl/tmr8_timer.v
// 8-bit timer/counter with shared prescaler, overflow flag and interrupt logic.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`include "tmr8_map.vh"
module tmr8_timer #(
   parameter ADDR_W = 8
) (
   // Clock and reset
   input wire CLK,
   input wire SYS_RST,
   // Register port
   input wire [ADDR_W-1:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [7:0] RDATA,
   // Core status and watchdog link
   input wire SLEEP,
   input wire WATCHDOG_CLEAR,
   input wire WATCHDOG_TICK,
   output wire WATCHDOG_SCALED_TICK,
   // External count input
   input wire EXT_COUNT_IN,
   // Interrupt
   output wire IRQ,
   output wire OVF_IRQ_REQ
);

   // State held across clocks.
   reg [7:0] option_reg;
   reg [7:0] count_reg;
   reg [7:0] presc_reg;
   reg [1:0] phase_reg;
   reg [1:0] hold_reg;
   reg ovf_flag_reg;
   reg ovf_en_reg;
   reg [1:0] irq_stat_reg;
   reg [1:0] irq_en_reg;
   reg ext_s1_reg;
   reg ext_s2_reg;
   reg ext_prev_reg;
   reg pend_reg;
   // Values worked out each cycle.
   reg sync_event;
   reg [7:0] read_next;
   reg [7:0] presc_next;
   reg [7:0] count_next;
   reg tick_raw;
   reg presc_out;
   reg count_step;
   reg wrap;
   // Decoded controls.
   wire wr_option;
   wire wr_intctl;
   wire wr_irq_en;
   wire wr_irq_clr;
   wire [1:0] stat_event;
   wire [2:0] ratio;
   wire src_ext;
   wire to_watchdog;
   wire ext_edge;
   wire wr_count;
   wire sample_phase;
   wire cycle_end;

   // Decodes a register address match.
   function hit;
      input [ADDR_W-1:0] a;
      input [7:0] target;
      begin
         hit = (a == target[ADDR_W-1:0]);
      end
   endfunction

   // Low prescaler bits that must all be set on the last tick of a prescale period.
   function [7:0] ratio_mask;
      input [2:0] r;
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            ratio_mask[i] = (i <= r);
         end
      end
   endfunction

   // True when the current tick completes one period of the selected ratio.
   function ratio_done;
      input [7:0] count;
      input [2:0] r;
      begin
         ratio_done = ((count & ratio_mask(r)) == ratio_mask(r));
      end
   endfunction

   assign ratio = option_reg[2:0];
   assign src_ext = option_reg[`TMR8_OPT_SRC];
   assign to_watchdog = option_reg[`TMR8_OPT_ASSIGN];
   assign wr_count = WR && hit(ADDR, `TMR8_ADDR_COUNT);
   assign wr_option = WR && hit(ADDR, `TMR8_ADDR_OPTION);
   assign wr_intctl = WR && hit(ADDR, `TMR8_ADDR_INTCTL);
   assign wr_irq_en = WR && hit(ADDR, `TMR8_ADDR_IRQ_EN);
   assign wr_irq_clr = WR && hit(ADDR, `TMR8_ADDR_IRQ_CLR);
   // Bit 1 flags a count write that lands while an earlier write still holds the count,
   // which usually means software is fighting itself over the timer.
   assign stat_event = {wr_count && (hold_reg != 2'h0), wrap};
   // Four clocks make one instruction cycle; phases 1 and 3 stand for Q2 and Q4.
   assign sample_phase = phase_reg[0];
   assign cycle_end = (phase_reg == 2'h3);

   // The phase counter freezes in sleep, which also freezes both sample phases
   // and the instruction tick; a phase frozen at 3 keeps cycle_end high, so the hold still counts down.
   always @(posedge CLK) begin
      if (SYS_RST) begin
         phase_reg <= 2'h0;
      end else if (!SLEEP) begin
         phase_reg <= phase_reg + 2'h1;
      end
   end

   // The first stage is read only by the second.
   // All stages reset low, the idle level of the pin, so reset makes no false edge.
   always @(posedge CLK) begin
      if (SYS_RST) begin
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
      end else begin
         ext_s1_reg <= EXT_COUNT_IN;
         ext_s2_reg <= ext_s1_reg;
         ext_prev_reg <= ext_s2_reg;
      end
   end

   assign ext_edge = option_reg[`TMR8_OPT_EDGE] ? (ext_prev_reg && !ext_s2_reg) :
                     (!ext_prev_reg && ext_s2_reg);

   // Prescaler input and output selection.
   always @* begin
      if (to_watchdog) begin
         tick_raw = WATCHDOG_TICK;
      end else if (src_ext) begin
         tick_raw = ext_edge;
      end else begin
         tick_raw = cycle_end;
      end
      presc_next = presc_reg;
      if (tick_raw) begin
         presc_next = presc_reg + 8'h01;
      end
      // ratio two to n plus one
      presc_out = tick_raw && ratio_done(presc_reg, ratio);
   end

   // The watchdog postscaler output; the watchdog itself lives elsewhere.
   // The watchdog sees the same period decode as the counter when it holds the prescaler.
   assign WATCHDOG_SCALED_TICK = to_watchdog ? presc_out : WATCHDOG_TICK;

   // A clear wins over a tick in the same cycle, so software gets a fresh period after it writes
   // the count while the counter holds the prescaler, or clears the watchdog while the watchdog holds it.
   // prescaler has no register path
   always @(posedge CLK) begin
      if (SYS_RST) begin
         presc_reg <= 8'h00;
      end else if (!to_watchdog && wr_count) begin
         presc_reg <= 8'h00;
      end else if (to_watchdog && WATCHDOG_CLEAR) begin
         presc_reg <= 8'h00;
      end else if (!SLEEP) begin
         presc_reg <= presc_next;
      end
   end

   // Count event source: the divided edge when the counter holds the prescaler,
   // the raw synchronised edge otherwise.
   always @* begin
      if (!to_watchdog) begin
         sync_event = presc_out;
      end else begin
         sync_event = ext_edge;
      end
   end

   // An event that lands between sample phases waits here for the next Q2 or Q4,
   // so it is delayed by at most one clock rather than lost.
   always @(posedge CLK) begin
      if (SYS_RST) begin
         pend_reg <= 1'b0;
      end else if (sample_phase) begin
         pend_reg <= 1'b0;
      end else if (src_ext && sync_event) begin
         pend_reg <= 1'b1;
      end
   end

   always @* begin
      if (!src_ext && to_watchdog) begin
         count_step = cycle_end;
      end else if (!src_ext) begin
         count_step = presc_out;
      end else begin
         // three to four periods late
         // The pin reaches the count three to four clocks after it moves.
         count_step = sample_phase && (pend_reg || sync_event);
      end
      if (SLEEP || (hold_reg != 2'h0)) begin
         count_step = 1'b0;
      end
      count_next = count_reg + 8'h01;
      // A write of ff never counts as a wrap; a step due from ff does, even when a write replaces the count.
      wrap = count_step && (count_reg == 8'hff);
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         count_reg <= 8'h00;
         hold_reg <= 2'h0;
      end else if (wr_count) begin
         count_reg <= WDATA;
         hold_reg <= `TMR8_WRITE_HOLD;
      end else begin
         if (count_step) begin
            count_reg <= count_next;
         end
         // The hold counts instruction-cycle ends, so it lasts five to eight clocks: a write
         // in phase 0, 1, 2 or 3 holds the count seven, six, five or eight clocks.
         if (cycle_end && (hold_reg != 2'h0)) begin
            hold_reg <= hold_reg - 2'h1;
         end
      end
   end

   // Option register and interrupt-control bits.
   always @(posedge CLK) begin
      if (SYS_RST) begin
         option_reg <= `TMR8_OPT_RESET;
         ovf_en_reg <= 1'b0;
         ovf_flag_reg <= 1'b0;
      end else begin
         // Changing the source mid-count may add or lose one step.
         if (wr_option) begin
            option_reg <= WDATA;
         end
         if (wr_intctl) begin
            ovf_en_reg <= WDATA[`TMR8_INT_OVF_EN];
         end
         // flag held until written zero
         // A wrap in the same cycle as a clearing write wins, so no overflow is lost.
         if (wrap) begin
            ovf_flag_reg <= 1'b1;
         end else if (wr_intctl) begin
            ovf_flag_reg <= WDATA[`TMR8_INT_OVF_FLAG];
         end
      end
   end

   assign OVF_IRQ_REQ = ovf_flag_reg && ovf_en_reg;

   // Status bit 0 is overflow, bit 1 is a write during the hold window.
   always @(posedge CLK) begin
      if (SYS_RST) begin
         irq_stat_reg <= 2'h0;
         irq_en_reg <= 2'h0;
      end else begin
         if (wr_irq_en) begin
            irq_en_reg <= WDATA[1:0];
         end
         // An event in the clearing cycle stays visible, since set wins over clear.
         if (wr_irq_clr) begin
            irq_stat_reg <= (irq_stat_reg & ~WDATA[1:0]) | stat_event;
         end else begin
            irq_stat_reg <= irq_stat_reg | stat_event;
         end
      end
   end

   // The output is a level; it drops only when software clears the bit or its enable.
   assign IRQ = |(irq_stat_reg & irq_en_reg);

   // Read multiplexer; unmapped addresses give zero, and nothing maps the prescaler.
   always @* begin
      read_next = 8'h00;
      if (hit(ADDR, `TMR8_ADDR_COUNT)) begin
         read_next = count_reg;
      end else if (hit(ADDR, `TMR8_ADDR_OPTION)) begin
         read_next = option_reg;
      end else if (hit(ADDR, `TMR8_ADDR_INTCTL)) begin
         // Interrupt-control holds the enable at bit 5 and the flag at bit 2.
         read_next = {2'h0, ovf_en_reg, 2'h0, ovf_flag_reg, 2'h0};
      end else if (hit(ADDR, `TMR8_ADDR_IRQ_STAT)) begin
         read_next = {6'h00, irq_stat_reg};
      end else if (hit(ADDR, `TMR8_ADDR_IRQ_EN)) begin
         read_next = {6'h00, irq_en_reg};
      end
   end

   // Read data appear in the cycle after the strobe and return to zero after it,
   // so a stale word is never mistaken for a fresh read.
   always @(posedge CLK) begin
      if (SYS_RST) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         RDATA <= read_next;
      end else begin
         RDATA <= 8'h00;
      end
   end

endmodule // tmr8_timer

// file: tb/tmr8_src.sv
// Behavioural source of edges on the external count input.
`timescale 1ns/10ps
module tmr8_src (
   // Clock and pin
   input wire clk,
   output logic ext
);
   initial ext = 1'b0;
   task automatic drive(input logic v, input int hold);
      begin
         ext <= v;
         repeat (hold) @(posedge clk);
      end
   endtask
endmodule // tmr8_src

// file: tb/tmr8_chk.sv
// Concurrent checks on the timer's register port, interrupt and tick outputs.
`timescale 1ns/10ps
`include "tmr8_map.vh"
module tmr8_chk #(
   parameter ADDR_W = 8
) (
   // Clock and reset
   input logic CLK,
   input logic SYS_RST,
   // Register port
   input logic [ADDR_W-1:0] ADDR,
   input logic [7:0] WDATA,
   input logic WR,
   input logic RD,
   input logic [7:0] RDATA,
   // Core status, ticks and interrupt
   input logic SLEEP,
   input logic WATCHDOG_TICK,
   input logic WATCHDOG_SCALED_TICK,
   input logic IRQ,
   input logic OVF_IRQ_REQ
);
   reg [7:0] opt_reg;
   reg [7:0] ctl_reg;
   reg [7:0] ien_reg;
   // Shadows of the writable controls, so read data can be judged without the bodies.
   always @(posedge CLK) begin
      if (SYS_RST) begin
         opt_reg <= `TMR8_OPT_RESET;
         ctl_reg <= 8'h00;
         ien_reg <= 8'h00;
      end else if (WR) begin
         opt_reg <= (ADDR == `TMR8_ADDR_OPTION) ? WDATA : opt_reg;
         ctl_reg <= (ADDR == `TMR8_ADDR_INTCTL) ? WDATA : ctl_reg;
         ien_reg <= (ADDR == `TMR8_ADDR_IRQ_EN) ? WDATA : ien_reg;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   sequence s_rd_opt;
      RD && ADDR == `TMR8_ADDR_OPTION;
   endsequence
   sequence s_rd_ctl;
      RD && ADDR == `TMR8_ADDR_INTCTL && ctl_reg[`TMR8_INT_OVF_EN];
   endsequence
   a_option_read_back: assert property (s_rd_opt |=> RDATA == opt_reg)
      else $error("option read back wrong");
   a_flag_read_match: assert property (s_rd_ctl |=> RDATA[2] == $past(OVF_IRQ_REQ))
      else $error("flag read disagrees with request");
   a_request_masked: assert property (OVF_IRQ_REQ |-> ctl_reg[`TMR8_INT_OVF_EN])
      else $error("request while masked");
   a_flag_stays_set: assert property (OVF_IRQ_REQ && !(WR && ADDR == `TMR8_ADDR_INTCTL)
      |=> OVF_IRQ_REQ)
      else $error("flag dropped without a write");
   a_sleep_no_wrap: assert property (SLEEP && !WR && !OVF_IRQ_REQ |=> !OVF_IRQ_REQ)
      else $error("overflow raised in sleep");
   a_no_scaler_path: assert property (RD && !(ADDR inside {`TMR8_ADDR_COUNT,
      `TMR8_ADDR_INTCTL, `TMR8_ADDR_OPTION, `TMR8_ADDR_IRQ_STAT, `TMR8_ADDR_IRQ_EN})
      |=> RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_tick_gated: assert property (WATCHDOG_SCALED_TICK |-> WATCHDOG_TICK)
      else $error("scaled tick without base tick");
   a_irq_enabled: assert property (IRQ |-> ien_reg[1:0] != 2'b00)
      else $error("interrupt with nothing enabled");
endmodule // tmr8_chk
bind tmr8_timer tmr8_chk #(.ADDR_W(ADDR_W)) tmr8_chk_i (.CLK(CLK), .SYS_RST(SYS_RST),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEP(SLEEP),
   .WATCHDOG_TICK(WATCHDOG_TICK), .WATCHDOG_SCALED_TICK(WATCHDOG_SCALED_TICK), .IRQ(IRQ),
   .OVF_IRQ_REQ(OVF_IRQ_REQ));

// file: tb/tmr8_timer_test.sv
// Self-checking bench for the 8-bit timer with shared prescaler.
`timescale 1ns/10ps
`include "tmr8_map.vh"
module tmr8_timer_test;
   localparam [7:0] OPT = `TMR8_ADDR_OPTION;
   localparam [7:0] CNT = `TMR8_ADDR_COUNT;
   localparam [7:0] CTL = `TMR8_ADDR_INTCTL;
   reg CLK, SYS_RST, WR, RD, SLEEP, WATCHDOG_CLEAR, WATCHDOG_TICK;
   reg [7:0] ADDR, WDATA, a, b;
   wire [7:0] RDATA;
   wire EXT_COUNT_IN, WATCHDOG_SCALED_TICK, IRQ, OVF_IRQ_REQ;
   integer err_count = 0;
   integer comparisons = 0;
   integer n;
   tmr8_src tmr8_src_i (.clk(CLK), .ext(EXT_COUNT_IN));
   tmr8_timer tmr8_timer_i (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEP(SLEEP), .WATCHDOG_CLEAR(WATCHDOG_CLEAR),
      .WATCHDOG_TICK(WATCHDOG_TICK), .WATCHDOG_SCALED_TICK(WATCHDOG_SCALED_TICK),
      .EXT_COUNT_IN(EXT_COUNT_IN),
      .IRQ(IRQ), .OVF_IRQ_REQ(OVF_IRQ_REQ));
   task chk(input [7:0] seen, input [7:0] exp, input [63:0] what);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("unexpected %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   // The trailing idle edge keeps two back-to-back strobes from landing in one time step.
   task wr(input [7:0] ad, input [7:0] d);
      begin
         ADDR <= ad;
         WDATA <= d;
         WR <= 1'b1;
         @(posedge CLK);
         WR <= 1'b0;
         @(posedge CLK);
      end
   endtask
   task rd(input [7:0] ad, output [7:0] d);
      begin
         ADDR <= ad;
         RD <= 1'b1;
         @(posedge CLK);
         RD <= 1'b0;
         #1 d = RDATA;
         @(posedge CLK);
      end
   endtask
   task drv(input v, input [7:0] exp);
      begin
         tmr8_src_i.drive(v, 7);
         rd(CNT, a);
         chk(a, exp, "extcount");
      end
   endtask
   task t_timer;
      begin
         rd(OPT, a);
         chk(a, `TMR8_OPT_RESET, "optreset");
         rd(8'h02, a);
         chk(a, 8'h00, "unmapped");
         wr(OPT, 8'h08);
         wr(CNT, 8'h10);
         rd(CNT, a);
         chk(a, 8'h10, "hold");
         repeat (8) @(posedge CLK);
         rd(CNT, a);
         repeat (38) @(posedge CLK);
         rd(CNT, b);
         chk(b - a, 8'h0a, "rate");
         $display("timer test done");
      end
   endtask
   task t_scale;
      begin
         for (n = 0; n < 8; n = n + 1) begin
            wr(OPT, n[7:0]);
            wr(CNT, 8'h00);
            repeat (10) @(posedge CLK);
            rd(CNT, a);
            repeat ((24 << n) - 2) @(posedge CLK);
            rd(CNT, b);
            chk(b - a, 8'h03, "ratio");
         end
         $display("prescale test done");
      end
   endtask
   task t_overflow;
      begin
         wr(OPT, 8'h08);
         wr(CTL, 8'h20);
         wr(`TMR8_ADDR_IRQ_EN, 8'h01);
         wr(CNT, 8'hff);
         repeat (16) @(posedge CLK);
         #1 chk({7'h00, OVF_IRQ_REQ}, 8'h01, "ovfreq");
         chk({7'h00, IRQ}, 8'h01, "irq");
         @(posedge CLK);
         wr(CTL, 8'h04);
         rd(CTL, a);
         chk(a, 8'h04, "flagkept");
         chk({7'h00, OVF_IRQ_REQ}, 8'h00, "masked");
         wr(`TMR8_ADDR_IRQ_CLR, 8'h01);
         chk({7'h00, IRQ}, 8'h00, "irqclr");
         wr(CTL, 8'h00);
         rd(CTL, a);
         chk(a, 8'h00, "flagclr");
         SLEEP <= 1'b1;
         rd(CNT, a);
         repeat (40) @(posedge CLK);
         rd(CNT, b);
         chk(b, a, "sleep");
         SLEEP <= 1'b0;
         $display("overflow test done");
      end
   endtask
   // Edge select only changes while the input sits at a level that makes no false edge.
   task t_external;
      begin
         wr(OPT, 8'h28);
         wr(CNT, 8'h00);
         repeat (8) @(posedge CLK);
         drv(1'b1, 8'h01);
         wr(OPT, 8'h38);
         drv(1'b0, 8'h02);
         drv(1'b1, 8'h02);
         drv(1'b0, 8'h03);
         wr(OPT, 8'h20);
         wr(CNT, 8'h00);
         repeat (8) @(posedge CLK);
         for (n = 0; n < 4; n = n + 1) begin
            tmr8_src_i.drive(1'b1, 3);
            tmr8_src_i.drive(1'b0, 3);
         end
         repeat (8) @(posedge CLK);
         rd(CNT, a);
         chk(a, 8'h02, "extscale");
         WATCHDOG_TICK <= 1'b1;
         #1 chk({7'h00, WATCHDOG_SCALED_TICK}, 8'h01, "tick");
         @(posedge CLK);
         WATCHDOG_TICK <= 1'b0;
         // Watchdog at 1:2: a clear before each of the first two ticks keeps both silent.
         wr(OPT, 8'h08);
         for (n = 0; n < 3; n = n + 1) begin
            WATCHDOG_CLEAR <= (n < 2);
            @(posedge CLK);
            WATCHDOG_CLEAR <= 1'b0;
            WATCHDOG_TICK <= 1'b1;
            #1 chk({7'h00, WATCHDOG_SCALED_TICK}, {7'h00, n == 2}, "wdclear");
            @(posedge CLK);
            WATCHDOG_TICK <= 1'b0;
         end
         $display("external test done");
      end
   endtask
   task stop_test;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, err_count);
         if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end
   initial begin
      {WR, RD, SLEEP, WATCHDOG_CLEAR, WATCHDOG_TICK, ADDR, WDATA} = 21'h0;
      SYS_RST = 1'b1;
      repeat (16) @(posedge CLK);
      SYS_RST <= 1'b0;
      t_timer;
      t_scale;
      t_overflow;
      t_external;
      stop_test;
   end
   initial begin
      #1000000;
      err_count = err_count + 1;
      stop_test;
   end
endmodule // tmr8_timer_test
